// file: slm_pkg.sv
/*
 * slm_pkg: shared constants, types and register map for the serial link lane mapper.
 * Assumes a 32-bit AXI4-Lite register bus and a 200 MHz single clock.
 */
package slm_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] SLM_OFF_MODE = 8'h00;
   localparam logic [7:0] SLM_OFF_KFRM = 8'h04;
   localparam logic [7:0] SLM_OFF_DID = 8'h08;
   localparam logic [7:0] SLM_OFF_SYNC = 8'h0C;
   localparam logic [7:0] SLM_OFF_CTRL = 8'h10;
   localparam logic [7:0] SLM_OFF_THR0 = 8'h14;
   localparam logic [7:0] SLM_OFF_THR1 = 8'h18;
   localparam logic [7:0] SLM_OFF_STAT = 8'h1C;
   localparam logic [7:0] SLM_OFF_LANE = 8'h20;

   // ----------------------------------------
   // modes and fields
   // ----------------------------------------
   localparam logic [7:0] SLM_MODE_D8 = 8'h27;   // dual channel, decimate by 8, two lanes
   localparam logic [7:0] SLM_MODE_D16 = 8'h38;  // dual channel, decimate by 16, two lanes
   localparam logic [7:0] SLM_MODE_RST = 8'h27;
   localparam logic [7:0] SLM_KFRM_RST = 8'h1F;
   localparam logic [7:0] SLM_KFRM_MIN = 8'h03;
   localparam logic [7:0] SLM_KFRM_MAX = 8'hFF;
   localparam logic [7:0] SLM_DID_RST = 8'h00;
   localparam logic [14:0] SLM_THR_RST = 15'h7FFF;
   localparam logic [1:0] SLM_RESP_OK = 2'h0;
   localparam logic [1:0] SLM_RESP_ERR = 2'h2;
   localparam int SLM_LANES = 8;
   localparam logic [7:0] SLM_ACTIVE_MASK = 8'h01;
   localparam logic [1:0] SLM_OCTETS = 2'h3;

   typedef enum logic [1:0] {
      SLM_SYNC_CRC12 = 2'h0,
      SLM_SYNC_FEC = 2'h1
   } slm_sync_e;

   typedef enum logic [1:0] {
      SLM_ST_IDLE = 2'b00,
      SLM_ST_RUN = 2'b01,
      SLM_ST_STOP = 2'b11
   } slm_state_e;

   // one complex sample pair for one channel
   typedef struct packed {
      logic [14:0] inphase;
      logic [14:0] quadrature;
   } slm_iq_s;

   // octet stream of one lane
   typedef struct packed {
      logic [7:0] octet;
      logic valid;
      logic frame_start;
      logic multi_start;
   } slm_lane_s;
endpackage : slm_pkg

// file: slm_lane_packer.sv
/*
 * slm_lane_packer: packs one channel's I/Q pair with overrange flags into four octets.
 * Assumes flags are computed by the caller and the octet index is driven by the top.
 */
`timescale 1ns/10ps
module slm_lane_packer
   import slm_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic load,
   input wire slm_iq_s sample,
   input wire logic flag_low,
   input wire logic flag_high,
   input wire logic [1:0] octet_idx,
   output logic [7:0] octet_out
);
   logic [31:0] frame_r;

   // ----------------------------------------
   // frame word, msb first
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         frame_r <= 32'h0000_0000;
      end else if (clk_en && load) begin
         frame_r <= {sample.inphase, flag_low, sample.quadrature, flag_high};
      end
   end

   always_comb begin
      case (octet_idx)
         2'h0: octet_out = frame_r[31:24];
         2'h1: octet_out = frame_r[23:16];
         2'h2: octet_out = frame_r[15:8];
         default: octet_out = frame_r[7:0];
      endcase
   end
endmodule : slm_lane_packer

// file: slm_lane_mapper.sv
/*
 * slm_lane_mapper: transport/link configuration and two-lane octet mapping for two links.
 * Assumes one 200 MHz clock, AXI4-Lite register access, and a sample strobe per frame.
 */
`timescale 1ns/10ps

// Summary of operation
// - mode 39: lane A0 octets 0-1 in-phase plus flag, 2-3 quadrature plus flag
// - mode 56 uses the same two-lane layout as mode 39
// - sync header mode selects CRC detection or forward error correction
// - CRC mode produces only the 12-bit CRC, never the 3-bit variant
// - FEC mode lets the receiver detect and correct bit errors
// - the link mode value is held for readback only and selects no setting; only listed modes are accepted
// - frames per multiframe field sets multiframe length within the allowed range
// - sixteen lanes form two eight-lane links, both links always used
// - each link uses lowest lanes and powers down the unused upper lanes
// - link A identifier equals programmed value, link B programmed value plus one
// - lane identifiers are the lane index 0 to 7 within each link
// - each lane word is a 15-bit component followed by one overrange bit
// - samples go out most significant bit first
// - flag low above threshold zero, flag high above threshold one
module slm_lane_mapper
   import slm_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // decimated samples, one pair per channel per frame
   input wire slm_iq_s chan_a_iq,
   input wire slm_iq_s chan_b_iq,
   input wire logic sample_valid,
   // lanes
   output slm_lane_s link_a_lane_zero,
   output slm_lane_s link_b_lane_zero,
   output logic [7:0] link_a_lane_en,
   output logic [7:0] link_b_lane_en,
   output logic [7:0] link_a_did,
   output logic [7:0] link_b_did,
   output logic [23:0] link_a_lane_ids,
   output logic [23:0] link_b_lane_ids,
   output logic sync_fec_en,
   output logic sync_crc12_en
);
   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   logic [7:0] link_mode_select_r;
   logic [7:0] multiframe_frames_field_r;
   logic [7:0] did_r;
   slm_sync_e sync_mode_r;
   logic run_r;
   logic [14:0] over_threshold_zero_r;
   logic [14:0] over_threshold_one_r;
   logic cfg_err_r;
   slm_state_e state_r;
   logic idle;
   assign idle = (state_r == SLM_ST_IDLE);

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_go;
   logic wr_hit;
   assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
   assign wr_hit = (aw_addr_r == SLM_OFF_MODE) || (aw_addr_r == SLM_OFF_KFRM) ||
      (aw_addr_r == SLM_OFF_DID) || (aw_addr_r == SLM_OFF_SYNC) ||
      (aw_addr_r == SLM_OFF_CTRL) || (aw_addr_r == SLM_OFF_THR0) ||
      (aw_addr_r == SLM_OFF_THR1) || (aw_addr_r == SLM_OFF_STAT) ||
      (aw_addr_r == SLM_OFF_LANE);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SLM_RESP_OK;
      end else if (clk_en) begin
         s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? SLM_RESP_OK : SLM_RESP_ERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   logic wr_cfg;
   // config writes are dropped unless idle so frames never mix settings
   assign wr_cfg = wr_go && w_strb_r[0] && idle;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         link_mode_select_r <= SLM_MODE_RST;
         multiframe_frames_field_r <= SLM_KFRM_RST;
         did_r <= SLM_DID_RST;
         sync_mode_r <= SLM_SYNC_CRC12;
         over_threshold_zero_r <= SLM_THR_RST;
         over_threshold_one_r <= SLM_THR_RST;
         cfg_err_r <= 1'b0;
      end else if (clk_en && wr_cfg) begin
         case (aw_addr_r)
            SLM_OFF_MODE: begin
               if (w_data_r[7:0] == SLM_MODE_D8 || w_data_r[7:0] == SLM_MODE_D16) begin
                  link_mode_select_r <= w_data_r[7:0];
               end else begin
                  cfg_err_r <= 1'b1;
               end
            end
            SLM_OFF_KFRM: begin
               if (w_data_r[7:0] >= SLM_KFRM_MIN) begin
                  multiframe_frames_field_r <= w_data_r[7:0];
               end else begin
                  cfg_err_r <= 1'b1;
               end
            end
            SLM_OFF_DID: did_r <= w_data_r[7:0];
            SLM_OFF_SYNC: begin
               // only two choices exist; no 3-bit CRC encoding is accepted
               if (w_data_r[1:0] == SLM_SYNC_FEC) begin
                  sync_mode_r <= SLM_SYNC_FEC;
               end else if (w_data_r[1:0] == SLM_SYNC_CRC12) begin
                  sync_mode_r <= SLM_SYNC_CRC12;
               end else begin
                  cfg_err_r <= 1'b1;
               end
            end
            SLM_OFF_THR0: over_threshold_zero_r <= w_data_r[14:0];
            SLM_OFF_THR1: over_threshold_one_r <= w_data_r[14:0];
            SLM_OFF_STAT: cfg_err_r <= cfg_err_r & ~w_data_r[0];
            default: cfg_err_r <= cfg_err_r;
         endcase
      end
   end

   // run bit is writable any time so the link can be stopped
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         run_r <= 1'b0;
      end else if (clk_en && wr_go && w_strb_r[0] && aw_addr_r == SLM_OFF_CTRL) begin
         run_r <= w_data_r[0];
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   logic [31:0] rd_mux;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case ({s_axi_araddr[7:2], 2'b00})
         SLM_OFF_MODE: rd_mux = {24'h000000, link_mode_select_r};
         SLM_OFF_KFRM: rd_mux = {24'h000000, multiframe_frames_field_r};
         SLM_OFF_DID: rd_mux = {24'h000000, did_r};
         SLM_OFF_SYNC: rd_mux = {30'h00000000, sync_mode_r};
         SLM_OFF_CTRL: rd_mux = {31'h00000000, run_r};
         SLM_OFF_THR0: rd_mux = {17'h00000, over_threshold_zero_r};
         SLM_OFF_THR1: rd_mux = {17'h00000, over_threshold_one_r};
         SLM_OFF_STAT: rd_mux = {28'h0000000, state_r, idle, cfg_err_r};
         SLM_OFF_LANE: rd_mux = {16'h0000, link_b_lane_en, link_a_lane_en};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= SLM_RESP_OK;
      end else if (clk_en) begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? SLM_RESP_OK : SLM_RESP_ERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // framing state
   // ----------------------------------------
   logic [1:0] octet_r;
   logic [7:0] frame_cnt_r;
   logic frame_full_r;
   logic load;
   // a new pair is taken only at a frame boundary; other samples are dropped
   assign load = sample_valid && (state_r == SLM_ST_RUN) && (!frame_full_r ||
      octet_r == SLM_OCTETS);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= SLM_ST_IDLE;
         octet_r <= 2'h0;
         frame_cnt_r <= 8'h00;
         frame_full_r <= 1'b0;
      end else if (clk_en) begin
         case (state_r)
            SLM_ST_IDLE: if (run_r) state_r <= SLM_ST_RUN;
            SLM_ST_RUN: begin
               if (frame_full_r && octet_r == SLM_OCTETS) begin
                  frame_cnt_r <= (frame_cnt_r == multiframe_frames_field_r) ? 8'h00 :
                     frame_cnt_r + 8'h01;
               end
               if (load) begin
                  frame_full_r <= 1'b1;
                  octet_r <= 2'h0;
               end else if (frame_full_r && octet_r != SLM_OCTETS) begin
                  octet_r <= octet_r + 2'h1;
               end else if (frame_full_r) begin
                  frame_full_r <= 1'b0;
               end
               if (!run_r) state_r <= SLM_ST_STOP;
            end
            SLM_ST_STOP: begin
               frame_full_r <= 1'b0;
               octet_r <= 2'h0;
               frame_cnt_r <= 8'h00;
               state_r <= SLM_ST_IDLE;
            end
            default: state_r <= SLM_ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // packers and overrange flags
   // ----------------------------------------
   logic [7:0] octet_a;
   logic [7:0] octet_b;
   // flags follow the larger magnitude of the two components in each pair
   logic [14:0] mag_a;
   logic [14:0] mag_b;
   assign mag_a = (chan_a_iq.inphase > chan_a_iq.quadrature) ? chan_a_iq.inphase :
      chan_a_iq.quadrature;
   assign mag_b = (chan_b_iq.inphase > chan_b_iq.quadrature) ? chan_b_iq.inphase :
      chan_b_iq.quadrature;

   logic chan_a_over_flag_low;
   logic chan_a_over_flag_high;
   logic chan_b_over_flag_low;
   logic chan_b_over_flag_high;
   assign chan_a_over_flag_low = mag_a > over_threshold_zero_r;
   assign chan_a_over_flag_high = mag_a > over_threshold_one_r;
   assign chan_b_over_flag_low = mag_b > over_threshold_zero_r;
   assign chan_b_over_flag_high = mag_b > over_threshold_one_r;

   slm_lane_packer u_pack_a (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .load(load),
      .sample(chan_a_iq),
      .flag_low(chan_a_over_flag_low),
      .flag_high(chan_a_over_flag_high),
      .octet_idx(octet_r),
      .octet_out(octet_a)
   );

   slm_lane_packer u_pack_b (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .load(load),
      .sample(chan_b_iq),
      .flag_low(chan_b_over_flag_low),
      .flag_high(chan_b_over_flag_high),
      .octet_idx(octet_r),
      .octet_out(octet_b)
   );

   // ----------------------------------------
   // lane outputs and link parameters
   // ----------------------------------------
   logic [23:0] lid_vec;
   always_comb begin
      lid_vec = 24'h000000;
      for (int i = 0; i < SLM_LANES; i++) begin
         lid_vec[i*3 +: 3] = 3'(i);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         link_a_lane_zero <= '0;
         link_b_lane_zero <= '0;
         link_a_lane_en <= 8'h00;
         link_b_lane_en <= 8'h00;
         link_a_did <= 8'h00;
         link_b_did <= 8'h00;
         link_a_lane_ids <= 24'h000000;
         link_b_lane_ids <= 24'h000000;
         sync_fec_en <= 1'b0;
         sync_crc12_en <= 1'b0;
      end else if (clk_en) begin
         link_a_lane_zero <= '{octet: octet_a, valid: frame_full_r,
            frame_start: frame_full_r && octet_r == 2'h0,
            multi_start: frame_full_r && octet_r == 2'h0 && frame_cnt_r == 8'h00};
         link_b_lane_zero <= '{octet: octet_b, valid: frame_full_r,
            frame_start: frame_full_r && octet_r == 2'h0,
            multi_start: frame_full_r && octet_r == 2'h0 && frame_cnt_r == 8'h00};
         // both listed modes use lane 0 only; upper lanes stay powered down
         link_a_lane_en <= SLM_ACTIVE_MASK;
         link_b_lane_en <= SLM_ACTIVE_MASK;
         link_a_did <= did_r;
         link_b_did <= did_r + 8'h01;
         link_a_lane_ids <= lid_vec;
         link_b_lane_ids <= lid_vec;
         sync_fec_en <= (sync_mode_r == SLM_SYNC_FEC);
         sync_crc12_en <= (sync_mode_r == SLM_SYNC_CRC12);
      end
   end
endmodule : slm_lane_mapper

// file: slm_lane_mapper_props.sv
/* slm_lane_mapper_props: port-level checks of the lane mapper.
   Assumes bind into slm_lane_mapper with clk_en held high. */
`timescale 1ns/10ps
module slm_lane_mapper_props
   import slm_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire slm_lane_s link_a_lane_zero,
   input wire slm_lane_s link_b_lane_zero,
   input wire logic [7:0] link_a_lane_en,
   input wire logic [7:0] link_b_lane_en,
   input wire logic [7:0] link_a_did,
   input wire logic [7:0] link_b_did,
   input wire logic [23:0] link_a_lane_ids,
   input wire logic [23:0] link_b_lane_ids,
   input wire logic sync_fec_en,
   input wire logic sync_crc12_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // outputs are zero for a cycle after reset, so static checks wait
   logic [1:0] live_r;
   always_ff @(posedge clk) begin
      if (!reset_n) live_r <= 2'h0;
      else if (live_r != 2'h3) live_r <= live_r + 2'h1;
   end
   did_offset_a: assert property (live_r == 2'h3 |-> link_b_did == link_a_did + 8'h01)
      else $error("link B identifier is not link A plus one");
   lane_ids_a: assert property (live_r == 2'h3 |-> link_a_lane_ids == 24'hFAC688
      && link_b_lane_ids == 24'hFAC688) else $error("lane identifiers wrong");
   lane_power_a: assert property (live_r == 2'h3 |-> link_a_lane_en == SLM_ACTIVE_MASK
      && link_b_lane_en == SLM_ACTIVE_MASK) else $error("lane power enables wrong");
   sync_onehot_a: assert property (live_r == 2'h3 |-> sync_fec_en != sync_crc12_en)
      else $error("sync header mode not one-hot");
   frame_len_a: assert property (link_a_lane_zero.frame_start |-> link_a_lane_zero.valid[*4])
      else $error("frame shorter than four octets");
   lane_lockstep_a: assert property (link_a_lane_zero.valid == link_b_lane_zero.valid
      && link_a_lane_zero.frame_start == link_b_lane_zero.frame_start)
      else $error("the two links are out of step");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before rready");
   write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before bready");
   rd_error_a: assert property (s_axi_rvalid && s_axi_rresp == SLM_RESP_ERR |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
endmodule : slm_lane_mapper_props

// file: slm_rx_model.sv
/* slm_rx_model: receiving logic device, rebuilds one frame word per link.
   Assumes frames of four octets, octet 0 flagged by frame_start. */
`timescale 1ns/10ps
module slm_rx_model
   import slm_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire slm_lane_s lane_a,
   input wire slm_lane_s lane_b,
   output logic [31:0] word_a,
   output logic [31:0] word_b,
   output logic got
);
   logic [1:0] cnt_r;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_r <= 2'h0;
         got <= 1'b0;
      end else begin
         got <= 1'b0;
         if (lane_a.valid) begin
            word_a <= {word_a[23:0], lane_a.octet};
            word_b <= {word_b[23:0], lane_b.octet};
            cnt_r <= lane_a.frame_start ? 2'h1 : cnt_r + 2'h1;
            got <= !lane_a.frame_start && cnt_r == 2'h3;
         end
      end
   end
endmodule : slm_rx_model

// file: slm_lane_mapper_test.sv
/* slm_lane_mapper_test: self-checking bench for the lane mapper.
   Assumes the receiver model and the props checker are compiled before it. */
`timescale 1ns/10ps
module slm_lane_mapper_test;
   import slm_pkg::*;
   localparam logic [14:0] THR0 = 15'h2000;
   localparam logic [14:0] THR1 = 15'h5000;
   logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic sample_valid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   slm_iq_s iq_a = '0, iq_b = '0;
   logic awready, wready, bvalid, arready, rvalid, got, fec, crc;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, word_a, word_b;
   slm_lane_s lane_a, lane_b;
   logic [7:0] en_a, en_b, did_a, did_b, d;
   logic ms;
   logic [23:0] ids_a, ids_b;
   logic [33:0] rd_q[$];
   logic [1:0] b_q[$];
   logic [64:0] fr_q[$];
   int error_cnt = 0, compares = 0, k, j;
   integer seed = 32'h017C;

   always #2.5 clk = ~clk;

   slm_lane_mapper u_slm_lane_mapper (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .chan_a_iq(iq_a), .chan_b_iq(iq_b), .sample_valid(sample_valid),
      .link_a_lane_zero(lane_a), .link_b_lane_zero(lane_b), .link_a_lane_en(en_a),
      .link_b_lane_en(en_b), .link_a_did(did_a), .link_b_did(did_b), .link_a_lane_ids(ids_a),
      .link_b_lane_ids(ids_b), .sync_fec_en(fec), .sync_crc12_en(crc));
   slm_rx_model u_slm_rx_model (.clk(clk), .reset_n(reset_n), .lane_a(lane_a), .lane_b(lane_b),
      .word_a(word_a), .word_b(word_b), .got(got));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task results;
      if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   task drain;
      int n;
      n = 0;
      while (rd_q.size() + b_q.size() + fr_q.size() != 0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) begin
         error_cnt++;
         results();
      end
   endtask : drain
   task axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      int n;
      b_q.push_back(r);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 100);
      bready <= 1'b0;
      drain();
   endtask : axw
   task axr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      int n;
      rd_q.push_back({r, v});
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      rready <= 1'b0;
      drain();
   endtask : axr
   function automatic logic [31:0] fword(input slm_iq_s s);
      logic [14:0] m;
      m = (s.inphase > s.quadrature) ? s.inphase : s.quadrature;
      return {s.inphase, m > THR0, s.quadrature, m > THR1};
   endfunction : fword
   task frame_go(input logic m);
      slm_iq_s a, b;
      a = 30'($random(seed));
      b = 30'($random(seed));
      fr_q.push_back({m, fword(a), fword(b)});
      @(posedge clk);
      iq_a <= a;
      iq_b <= b;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      iq_a <= ~a;
      iq_b <= ~b;
      drain();
   endtask : frame_go

   always @(posedge clk) begin
      if (rvalid && rready) begin
         chk("rdata", rd_q[0][31:0], rdata);
         chk("rresp", 32'(rd_q[0][33:32]), 32'(rresp));
         void'(rd_q.pop_front());
      end
      if (bvalid && bready) begin
         chk("bresp", 32'(b_q[0]), 32'(bresp));
         void'(b_q.pop_front());
      end
      if (lane_a.frame_start) ms <= lane_a.multi_start;
      if (got) begin
         chk("lane_a_frame", fr_q[0][63:32], word_a);
         chk("lane_b_frame", fr_q[0][31:0], word_b);
         chk("multi_start", 32'(fr_q[0][64]), 32'(ms));
         void'(fr_q.pop_front());
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      axr(SLM_OFF_MODE, {24'h0, SLM_MODE_RST}, SLM_RESP_OK);
      axr(SLM_OFF_THR0, {17'h0, SLM_THR_RST}, SLM_RESP_OK);
      axr(8'h40, 32'h0, SLM_RESP_ERR);
      axw(8'h44, 32'h1, SLM_RESP_ERR);
      axw(SLM_OFF_KFRM, 32'h2, SLM_RESP_OK);
      axr(SLM_OFF_KFRM, {24'h0, SLM_KFRM_RST}, SLM_RESP_OK);
      axw(SLM_OFF_KFRM, {24'h0, SLM_KFRM_MIN}, SLM_RESP_OK);
      axr(SLM_OFF_KFRM, {24'h0, SLM_KFRM_MIN}, SLM_RESP_OK);
      axw(SLM_OFF_MODE, 32'h28, SLM_RESP_OK);
      axr(SLM_OFF_MODE, {24'h0, SLM_MODE_RST}, SLM_RESP_OK);
      axr(SLM_OFF_STAT, 32'h3, SLM_RESP_OK);
      axw(SLM_OFF_STAT, 32'h1, SLM_RESP_OK);
      axr(SLM_OFF_STAT, 32'h2, SLM_RESP_OK);
      for (k = 0; k < 3; k++) begin
         axw(SLM_OFF_SYNC, 32'(k), SLM_RESP_OK);
         repeat (2) @(posedge clk);
         chk("sync_fec_en", 32'(k != 0), 32'(fec));
         chk("sync_crc12_en", 32'(k == 0), 32'(crc));
      end
      d = 8'($random(seed));
      axw(SLM_OFF_DID, {24'h0, d}, SLM_RESP_OK);
      repeat (2) @(posedge clk);
      chk("link_a_did", 32'(d), 32'(did_a));
      chk("link_b_did", 32'(8'(d + 8'h01)), 32'(did_b));
      chk("lane_ids", {8'h88, 24'hFAC688}, {ids_a[7:0], ids_b[23:0]});
      chk("lane_en", 32'h0101, {16'h0, en_a, en_b});
      axw(SLM_OFF_THR0, {17'h0, THR0}, SLM_RESP_OK);
      axw(SLM_OFF_THR1, {17'h0, THR1}, SLM_RESP_OK);
      for (k = 0; k < 2; k++) begin
         axw(SLM_OFF_MODE, {24'h0, k ? SLM_MODE_D16 : SLM_MODE_D8}, SLM_RESP_OK);
         axr(SLM_OFF_MODE, {24'h0, k ? SLM_MODE_D16 : SLM_MODE_D8}, SLM_RESP_OK);
         axw(SLM_OFF_CTRL, 32'h1, SLM_RESP_OK);
         for (j = 0; j < 6; j++) frame_go(j % (SLM_KFRM_MIN + 1) == 0);
         axw(SLM_OFF_DID, {24'h0, ~d}, SLM_RESP_OK);
         chk("did_locked", 32'(d), 32'(did_a));
         axw(SLM_OFF_CTRL, 32'h0, SLM_RESP_OK);
         repeat (4) @(posedge clk);
      end
      results();
   end
endmodule : slm_lane_mapper_test

bind slm_lane_mapper slm_lane_mapper_props u_slm_lane_mapper_props (.clk(clk),
   .reset_n(reset_n), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .link_a_lane_zero(link_a_lane_zero), .link_b_lane_zero(link_b_lane_zero),
   .link_a_lane_en(link_a_lane_en), .link_b_lane_en(link_b_lane_en),
   .link_a_did(link_a_did), .link_b_did(link_b_did), .link_a_lane_ids(link_a_lane_ids),
   .link_b_lane_ids(link_b_lane_ids), .sync_fec_en(sync_fec_en),
   .sync_crc12_en(sync_crc12_en));
